/* File: hw/irq_pkg.sv */
// Constants shared by the UART interrupt and status logic.
package irq_pkg;
	// ---------------------------------------------------------------
	// Register offsets on the host register port
	// ---------------------------------------------------------------
	localparam logic [3:0] OFS_HOLDING = 4'h0;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h1;
	localparam logic [3:0] OFS_SOURCE_QUEUE = 4'h2;
	localparam logic [3:0] OFS_LINE_STATUS = 4'h5;
	localparam logic [3:0] OFS_MODEM_STATE = 4'h6;
	localparam logic [3:0] OFS_INPUT_STATE = 4'hb;
	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int IEN_RX = 0;
	localparam int IEN_TX = 1;
	localparam int IEN_LINE = 2;
	localparam int IEN_MODEM = 3;
	localparam int IEN_XOFF = 5;
	localparam int IEN_RTS = 6;
	localparam int IEN_CTS = 7;
	localparam int QC_ENABLE = 0;
	localparam int QC_TX_TRIG_LO = 4;
	localparam int QC_RX_TRIG_LO = 6;
	localparam logic [7:0] IEN_RESET = 8'h00;
	localparam logic [7:0] IEN_LOW_MASK = 8'h0f;
	localparam logic [7:0] IEN_HIGH_MASK = 8'hf0;
	localparam logic [1:0] TRIG_RESET = 2'h0;
	// ---------------------------------------------------------------
	// Source codes, bits 5 to 0, in priority order
	// ---------------------------------------------------------------
	localparam logic [5:0] SRC_LINE = 6'h06;
	localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
	localparam logic [5:0] SRC_RX_READY = 6'h04;
	localparam logic [5:0] SRC_TX_READY = 6'h02;
	localparam logic [5:0] SRC_MODEM = 6'h00;
	localparam logic [5:0] SRC_GPIO = 6'h30;
	localparam logic [5:0] SRC_XOFF = 6'h10;
	localparam logic [5:0] SRC_HANDSHAKE = 6'h20;
	localparam logic [5:0] SRC_NONE = 6'h01;
	// ---------------------------------------------------------------
	// FIFO sizes, trigger levels and timeout figures
	// ---------------------------------------------------------------
	localparam int FIFO_DEPTH = 64;
	localparam logic [6:0] FIFO_DEPTH_W = 7'h40;
	localparam logic [6:0] RX_TRIG_0 = 7'h08;
	localparam logic [6:0] RX_TRIG_1 = 7'h10;
	localparam logic [6:0] RX_TRIG_2 = 7'h38;
	localparam logic [6:0] RX_TRIG_3 = 7'h3c;
	localparam logic [6:0] TX_TRIG_0 = 7'h08;
	localparam logic [6:0] TX_TRIG_1 = 7'h10;
	localparam logic [6:0] TX_TRIG_2 = 7'h20;
	localparam logic [6:0] TX_TRIG_3 = 7'h38;
	localparam int TIMEOUT_CHARS = 4;
	localparam int TIMEOUT_EXTRA_BITS = 12;
	localparam int CHAR_BITS_DEFAULT = 10;
endpackage : irq_pkg

/* File: hw/level_sync.sv */
// Two-flop synchroniser for a bundle of slow pin levels.
`timescale 1ns/10ps
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk, // System clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic ce, // Clock enable.
	input wire logic [WIDTH-1:0] pin_in, // Asynchronous levels.
	output logic [WIDTH-1:0] sync_out // Levels in the clock domain.
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// First stage feeds only the second stage.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (ce) begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule : level_sync

/* File: hw/rx_idle_timer.sv */
// Receive idle timer that fires after four characters plus twelve bit times.
`timescale 1ns/10ps
module rx_idle_timer #(
	parameter int CHAR_BITS = irq_pkg::CHAR_BITS_DEFAULT
) (
	input wire logic mclk, // System clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic ce, // Clock enable.
	input wire logic bit_tick, // One pulse per bit time.
	input wire logic restart, // Character pushed or holding read.
	input wire logic rx_nonempty, // Receive queue holds data.
	output logic expire // One-cycle pulse on timeout.
);
	localparam int LIMIT = irq_pkg::TIMEOUT_CHARS * CHAR_BITS + irq_pkg::TIMEOUT_EXTRA_BITS;
	localparam logic [7:0] LIMIT_W = 8'(LIMIT);

	initial begin
		if (CHAR_BITS < 7 || CHAR_BITS > 12) $error("CHAR_BITS out of range");
	end

	logic [7:0] count_ff;
	logic fired_ff;

	// Counts bit times while data waits; fires once per idle period.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_ff <= 8'h00;
			fired_ff <= 1'b0;
		end else if (ce) begin
			if (restart || !rx_nonempty) begin
				count_ff <= 8'h00;
				fired_ff <= 1'b0;
			end else if (bit_tick && count_ff != LIMIT_W) begin
				count_ff <= count_ff + 8'h01;
			end else if (count_ff == LIMIT_W) begin
				fired_ff <= 1'b1;
			end
		end
	end

	assign expire = ce && rx_nonempty && !restart && !fired_ff && count_ff == LIMIT_W;
endmodule : rx_idle_timer

/* File: hw/uart_irq_status.sv */
// Interrupt enable, priority, status and clearing logic of the UART.
// Functional notes
// - FIFO on and enables 0-3 clear gives polled mode via line status bits.
// - Line status bits: 0 data ready, 1 overrun, 4:2 head error, 5 holding empty.
// - Line status bit 6 needs queue and shifter empty; bit 7 any errored character.
// - Enable 0 raises receive ready on a held character or trigger level.
// - Enable 1 raises transmit ready on empty or spaces above trigger; immediate.
// - Enable 2 raises line interrupt from bits 1-4 or 7; held while 7 set.
// - Overrun interrupts as soon as the overflowing character arrives.
// - Bit 7 covers parity, framing, break; bits 4:2 describe readable character.
// - Enable 3 gates modem interrupt; all enables reset to zero.
// - Enable bits 7:4 writable only with enhanced functions enabled.
// - Rising request-to-send or clear-to-send during auto flow raises interrupt.
// - Source read returns only the highest pending source.
// - Source codes follow the fixed priority table.
// - Source bit 0 reads 0 when pending, 1 when idle and at reset.
// - Receive timeout after four characters plus twelve bits; holding read clears.
// - Transmit ready cleared by a source read that returns it, or by a holding write.
// - Line interrupt clears when no errored character; receive ready below trigger.
// - Modem deltas raise modem interrupt; modem read clears it and handshake.
// - A general input toggle interrupts; input state read clears it.
// - Source bit 4 flags Xoff or special character; Xon clears Xoff, source read clears special.
// - Source bit 5 flags handshake change; bits 7:6 show FIFO enable.
// - Queue control bit 0 enables FIFOs; other bits need it written as 1.
// - Trigger codes select 8/16/56/60 receive and 8/16/32/56 transmit.
`timescale 1ns/10ps
module uart_irq_status #(
	parameter int GPIO_W = 4,
	parameter int CHAR_BITS = irq_pkg::CHAR_BITS_DEFAULT
) (
	input wire logic mclk, // System clock, 125 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic ce, // Clock enable, freezes all state when low.
	input wire logic [3:0] reg_addr, // Register offset.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	input wire logic [7:0] reg_wdata, // Write data.
	output logic [7:0] reg_rdata, // Read data, one cycle after strobe.
	input wire logic enh_enable, // Enhanced functions enabled.
	input wire logic [6:0] rx_count, // Receive queue fill.
	input wire logic [6:0] tx_count, // Transmit queue fill.
	input wire logic rx_push, // Character entered receive queue.
	input wire logic rx_overrun, // Character lost to a full queue.
	input wire logic [2:0] rx_head_err, // Break, framing, parity of head.
	input wire logic rx_err_any, // Some queued character has an error.
	input wire logic tsr_empty, // Transmit shifter idle.
	input wire logic rs485_auto, // Auto direction control active.
	input wire logic bit_tick, // One pulse per bit time.
	input wire logic [3:0] modem_delta, // Modem status change bits.
	input wire logic [GPIO_W-1:0] gpio_pin, // General inputs, asynchronous.
	input wire logic cts_n_pin, // Clear-to-send pin, asynchronous.
	input wire logic rts_n_out, // Request-to-send as driven.
	input wire logic auto_rts, // Auto request-to-send flow on.
	input wire logic auto_cts, // Auto clear-to-send flow on.
	input wire logic xoff_match, // Xoff character detected.
	input wire logic xon_match, // Xon character detected.
	input wire logic special_match, // Special character detected.
	output logic fifo_en, // FIFOs enabled.
	output logic [6:0] rx_trig, // Receive trigger level.
	output logic [6:0] tx_trig, // Transmit trigger level.
	output logic sleep_en, // Sleep mode enable.
	output logic irq_n // Interrupt request, active low.
);
	initial begin
		if (GPIO_W < 1 || GPIO_W > 8) $error("GPIO_W out of range");
	end

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	// Trigger level lookup for either queue.
	function automatic logic [6:0] trig_level(input logic [1:0] code, input logic is_rx);
		case (code)
			2'h0: trig_level = is_rx ? irq_pkg::RX_TRIG_0 : irq_pkg::TX_TRIG_0;
			2'h1: trig_level = is_rx ? irq_pkg::RX_TRIG_1 : irq_pkg::TX_TRIG_1;
			2'h2: trig_level = is_rx ? irq_pkg::RX_TRIG_2 : irq_pkg::TX_TRIG_2;
			default: trig_level = is_rx ? irq_pkg::RX_TRIG_3 : irq_pkg::TX_TRIG_3;
		endcase
	endfunction : trig_level

	// Register strobe decode.
	function automatic logic hit(input logic strobe, input logic [3:0] a, input logic [3:0] ofs);
		hit = ce && strobe && a == ofs;
	endfunction : hit

	logic wr_ien, wr_qc, wr_hold, rd_hold, rd_src, rd_line, rd_modem, rd_input;
	assign wr_ien = hit(reg_wr, reg_addr, irq_pkg::OFS_IRQ_ENABLE);
	assign wr_qc = hit(reg_wr, reg_addr, irq_pkg::OFS_SOURCE_QUEUE);
	assign wr_hold = hit(reg_wr, reg_addr, irq_pkg::OFS_HOLDING);
	assign rd_hold = hit(reg_rd, reg_addr, irq_pkg::OFS_HOLDING);
	assign rd_src = hit(reg_rd, reg_addr, irq_pkg::OFS_SOURCE_QUEUE);
	assign rd_line = hit(reg_rd, reg_addr, irq_pkg::OFS_LINE_STATUS);
	assign rd_modem = hit(reg_rd, reg_addr, irq_pkg::OFS_MODEM_STATE);
	assign rd_input = hit(reg_rd, reg_addr, irq_pkg::OFS_INPUT_STATE);

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------
	logic [7:0] irq_enable_reg_ff;
	logic fifo_en_ff;
	logic [1:0] rx_code_ff, tx_code_ff;

	// Enable register; upper half held unless enhanced functions are on.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_enable_reg_ff <= irq_pkg::IEN_RESET;
		end else if (wr_ien) begin
			irq_enable_reg_ff <= (reg_wdata & irq_pkg::IEN_LOW_MASK) |
				((enh_enable ? reg_wdata : irq_enable_reg_ff) & irq_pkg::IEN_HIGH_MASK);
		end
	end

	// Queue control: other bits only taken with the enable bit written as 1.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fifo_en_ff <= 1'b0;
			rx_code_ff <= irq_pkg::TRIG_RESET;
			tx_code_ff <= irq_pkg::TRIG_RESET;
		end else if (wr_qc) begin
			fifo_en_ff <= reg_wdata[irq_pkg::QC_ENABLE];
			if (reg_wdata[irq_pkg::QC_ENABLE]) begin
				rx_code_ff <= reg_wdata[irq_pkg::QC_RX_TRIG_LO +: 2];
				if (enh_enable) begin
					tx_code_ff <= reg_wdata[irq_pkg::QC_TX_TRIG_LO +: 2];
				end
			end
		end
	end

	assign fifo_en = fifo_en_ff;
	assign rx_trig = trig_level(rx_code_ff, 1'b1);
	assign tx_trig = trig_level(tx_code_ff, 1'b0);
	assign sleep_en = irq_enable_reg_ff[4];

	// -----------------------------------------------------------------
	// Pin synchronisers and timeout timer
	// -----------------------------------------------------------------
	logic [GPIO_W-1:0] gpio_s;
	logic cts_n_s, timeout_pulse;
	level_sync #(.WIDTH(GPIO_W + 1)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.pin_in({cts_n_pin, gpio_pin}),
		.sync_out({cts_n_s, gpio_s})
	);

	rx_idle_timer #(.CHAR_BITS(CHAR_BITS)) u_timer (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.bit_tick(bit_tick),
		.restart(rx_push || rd_hold),
		.rx_nonempty(rx_count != 7'h00),
		.expire(timeout_pulse)
	);

	// -----------------------------------------------------------------
	// Status conditions
	// -----------------------------------------------------------------
	logic rx_ready, tx_cond;
	logic [7:0] line_status;
	logic overrun_ff;
	// Ready conditions differ between FIFO and single-character mode.
	assign rx_ready = fifo_en_ff ? (rx_count >= rx_trig) : (rx_count != 7'h00);
	assign tx_cond = (fifo_en_ff ? ((irq_pkg::FIFO_DEPTH_W - tx_count) > tx_trig
		|| tx_count == 7'h00) : (tx_count == 7'h00))
		|| (rs485_auto && tx_count == 7'h00 && tsr_empty);
	// Line status snapshot used for polling and the line interrupt.
	assign line_status = {rx_err_any, (tx_count == 7'h00) && tsr_empty, tx_count == 7'h00,
		rx_head_err, overrun_ff, rx_count != 7'h00};

	// Overrun is caught the cycle the character is lost; set beats clear.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			overrun_ff <= 1'b0;
		end else if (ce) begin
			overrun_ff <= rx_overrun || (overrun_ff && !rd_line);
		end
	end

	// -----------------------------------------------------------------
	// Sticky event flags
	// -----------------------------------------------------------------
	logic tx_cond_ff, tx_en_ff, cts_n_ff, rts_n_ff;
	logic [GPIO_W-1:0] gpio_ff;
	logic tx_flag_ff, to_flag_ff, modem_flag_ff, gpio_flag_ff;
	logic xoff_flag_ff, spec_flag_ff, hs_flag_ff;
	logic [5:0] src_code;
	logic tx_set, hs_set;

	assign tx_set = (tx_cond && !tx_cond_ff)
		|| (tx_cond && irq_enable_reg_ff[irq_pkg::IEN_TX] && !tx_en_ff);
	assign hs_set = (auto_rts && irq_enable_reg_ff[irq_pkg::IEN_RTS] && rts_n_out && !rts_n_ff)
		|| (auto_cts && irq_enable_reg_ff[irq_pkg::IEN_CTS] && cts_n_s && !cts_n_ff);

	// Edge detector history.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_cond_ff <= 1'b0;
			tx_en_ff <= 1'b0;
			cts_n_ff <= 1'b0;
			rts_n_ff <= 1'b0;
			gpio_ff <= '0;
		end else if (ce) begin
			tx_cond_ff <= tx_cond;
			tx_en_ff <= irq_enable_reg_ff[irq_pkg::IEN_TX];
			cts_n_ff <= cts_n_s;
			rts_n_ff <= rts_n_out;
			gpio_ff <= gpio_s;
		end
	end

	// Event flags; in every case but the timeout, which a holding read suppresses, a new event wins over a same-cycle clear.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_flag_ff <= 1'b0;
			to_flag_ff <= 1'b0;
			modem_flag_ff <= 1'b0;
			gpio_flag_ff <= 1'b0;
			xoff_flag_ff <= 1'b0;
			spec_flag_ff <= 1'b0;
			hs_flag_ff <= 1'b0;
		end else if (ce) begin
			tx_flag_ff <= tx_set || (tx_flag_ff && tx_cond && !wr_hold
				&& !(rd_src && src_code == irq_pkg::SRC_TX_READY));
			to_flag_ff <= timeout_pulse || (to_flag_ff && !rd_hold);
			modem_flag_ff <= (modem_delta != 4'h0) || (modem_flag_ff && !rd_modem);
			gpio_flag_ff <= (gpio_s != gpio_ff) || (gpio_flag_ff && !rd_input);
			xoff_flag_ff <= xoff_match || (xoff_flag_ff && !xon_match);
			spec_flag_ff <= special_match || (spec_flag_ff && !rd_src);
			hs_flag_ff <= hs_set || (hs_flag_ff && !rd_modem);
		end
	end

	// -----------------------------------------------------------------
	// Priority encoder
	// -----------------------------------------------------------------
	logic line_pend, to_pend, rx_pend, tx_pend, modem_pend;
	logic gpio_pend, xoff_pend, hs_pend;
	assign line_pend = irq_enable_reg_ff[irq_pkg::IEN_LINE]
		&& (line_status[1] || line_status[4:2] != 3'h0 || line_status[7]);
	assign to_pend = irq_enable_reg_ff[irq_pkg::IEN_RX] && to_flag_ff;
	assign rx_pend = irq_enable_reg_ff[irq_pkg::IEN_RX] && rx_ready;
	assign tx_pend = irq_enable_reg_ff[irq_pkg::IEN_TX] && tx_flag_ff;
	assign modem_pend = irq_enable_reg_ff[irq_pkg::IEN_MODEM] && modem_flag_ff;
	assign gpio_pend = gpio_flag_ff;
	assign xoff_pend = enh_enable && irq_enable_reg_ff[irq_pkg::IEN_XOFF]
		&& (xoff_flag_ff || spec_flag_ff);
	assign hs_pend = enh_enable && hs_flag_ff
		&& (irq_enable_reg_ff[irq_pkg::IEN_RTS] || irq_enable_reg_ff[irq_pkg::IEN_CTS]);

	// Highest pending source only; the rest stay queued behind it, except the special-character flag, which any source read clears.
	always_comb begin
		if (line_pend) src_code = irq_pkg::SRC_LINE;
		else if (to_pend) src_code = irq_pkg::SRC_TIMEOUT;
		else if (rx_pend) src_code = irq_pkg::SRC_RX_READY;
		else if (tx_pend) src_code = irq_pkg::SRC_TX_READY;
		else if (modem_pend) src_code = irq_pkg::SRC_MODEM;
		else if (gpio_pend) src_code = irq_pkg::SRC_GPIO;
		else if (xoff_pend) src_code = irq_pkg::SRC_XOFF;
		else if (hs_pend) src_code = irq_pkg::SRC_HANDSHAKE;
		else src_code = irq_pkg::SRC_NONE;
	end

	// -----------------------------------------------------------------
	// Read data and request output
	// -----------------------------------------------------------------
	logic [7:0] rdata_ff;
	logic irq_n_ff;

	// Read data registered; unmapped offsets read as zero.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else if (ce && reg_rd) begin
			case (reg_addr)
				irq_pkg::OFS_IRQ_ENABLE: rdata_ff <= irq_enable_reg_ff;
				irq_pkg::OFS_SOURCE_QUEUE: rdata_ff <= {{2{fifo_en_ff}}, src_code};
				irq_pkg::OFS_LINE_STATUS: rdata_ff <= line_status;
				irq_pkg::OFS_INPUT_STATE: rdata_ff <= 8'(gpio_s);
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	// Request follows source bit 0, one cycle behind.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_n_ff <= 1'b1;
		end else if (ce) begin
			irq_n_ff <= src_code[0];
		end
	end

	assign reg_rdata = rdata_ff;
	assign irq_n = irq_n_ff;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	sequence s_line_err;
		ce && irq_enable_reg_ff[irq_pkg::IEN_LINE] && rx_err_any;
	endsequence
	sequence s_src_read_line;
		rd_src && reg_addr == irq_pkg::OFS_SOURCE_QUEUE;
	endsequence

	AST_IRQ_MATCH: assert property (@(posedge mclk) disable iff (rst)
		ce |=> irq_n == $past(src_code[0])) else $error("irq_n does not follow source");
	AST_LINE_HOLD: assert property (@(posedge mclk) disable iff (rst)
		s_line_err |-> src_code == irq_pkg::SRC_LINE) else $error("line source not top");
	AST_LINE_READ: assert property (@(posedge mclk) disable iff (rst)
		s_line_err ##0 s_src_read_line |=> reg_rdata[5:0] == irq_pkg::SRC_LINE)
		else $error("source read missed line code");
	AST_FIFO_BITS: assert property (@(posedge mclk) disable iff (rst)
		rd_src |=> reg_rdata[7:6] == {2{$past(fifo_en_ff)}}) else $error("fifo bits wrong");
	AST_OVERRUN: assert property (@(posedge mclk) disable iff (rst)
		ce && rx_overrun |=> line_status[1]) else $error("overrun not flagged");
	AST_TX_CLEAR: assert property (@(posedge mclk) disable iff (rst)
		wr_hold && !tx_set |=> !tx_flag_ff) else $error("holding write kept tx flag");
	AST_TIMEOUT_SET: assert property (@(posedge mclk) disable iff (rst)
		timeout_pulse |=> to_flag_ff) else $error("timeout not flagged");
	AST_MODEM_CLEAR: assert property (@(posedge mclk) disable iff (rst)
		rd_modem && modem_delta == 4'h0 && !hs_set |=> !modem_flag_ff && !hs_flag_ff)
		else $error("modem read did not clear");
	AST_HIGH_LOCK: assert property (@(posedge mclk) disable iff (rst)
		wr_ien && !enh_enable |=> irq_enable_reg_ff[7:4] == $past(irq_enable_reg_ff[7:4]))
		else $error("upper enables written while locked");
	AST_QC_IGNORE: assert property (@(posedge mclk) disable iff (rst)
		wr_qc && !reg_wdata[0] |=> !fifo_en_ff && $stable(rx_code_ff))
		else $error("queue control taken without enable");
	AST_IDLE_CODE: assert property (@(posedge mclk) disable iff (rst)
		irq_enable_reg_ff == 8'h00 && !gpio_flag_ff |-> src_code == irq_pkg::SRC_NONE)
		else $error("source pending with all disabled");
endmodule : uart_irq_status

/* File: tb/host_port_model.sv */
// Host controller model that drives the register port of the UART.
`timescale 1ns/10ps
module host_port_model (
	input wire logic mclk, // System clock.
	input wire logic [7:0] reg_rdata, // Read data from the device.
	output logic [3:0] reg_addr, // Register offset.
	output logic reg_wr, // Write strobe.
	output logic reg_rd, // Read strobe.
	output logic [7:0] reg_wdata // Write data.
);
	// Idle port at time zero.
	initial begin
		reg_addr = 4'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	// One-cycle write strobe, held until the edge that takes it.
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	// One-cycle read strobe; the registered data is taken one edge later.
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		d = reg_rdata;
	endtask : rd
endmodule : host_port_model

/* File: tb/test_uart_irq_status.sv */
// Self-checking testbench of the UART interrupt and status logic.
`timescale 1ns/10ps
module test_uart_irq_status;
	localparam logic [3:0] SQ = irq_pkg::OFS_SOURCE_QUEUE;
	localparam logic [3:0] EN = irq_pkg::OFS_IRQ_ENABLE;
	localparam int IDLE_TICKS = irq_pkg::TIMEOUT_CHARS * irq_pkg::CHAR_BITS_DEFAULT
		+ irq_pkg::TIMEOUT_EXTRA_BITS;
	logic mclk, rst, ce, enh_enable, rx_push, rx_overrun, rx_err_any, tsr_empty;
	logic rs485_auto, bit_tick, cts_n_pin, rts_n_out, auto_rts, auto_cts;
	logic xoff_match, xon_match, special_match, reg_wr, reg_rd, fifo_en, sleep_en, irq_n;
	logic [3:0] reg_addr, modem_delta, gpio_pin;
	logic [7:0] reg_wdata, reg_rdata, rv;
	logic [6:0] rx_count, tx_count, rx_trig, tx_trig;
	logic [2:0] rx_head_err;
	int n_errors, comparisons;

	host_port_model hst (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

	uart_irq_status uut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.enh_enable(enh_enable), .rx_count(rx_count), .tx_count(tx_count),
		.rx_push(rx_push), .rx_overrun(rx_overrun), .rx_head_err(rx_head_err),
		.rx_err_any(rx_err_any), .tsr_empty(tsr_empty), .rs485_auto(rs485_auto),
		.bit_tick(bit_tick), .modem_delta(modem_delta), .gpio_pin(gpio_pin),
		.cts_n_pin(cts_n_pin), .rts_n_out(rts_n_out), .auto_rts(auto_rts),
		.auto_cts(auto_cts), .xoff_match(xoff_match), .xon_match(xon_match),
		.special_match(special_match), .fifo_en(fifo_en), .rx_trig(rx_trig),
		.tx_trig(tx_trig), .sleep_en(sleep_en), .irq_n(irq_n));

	// Free-running 125 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Compares one value and counts the outcome.
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Reads a register and compares it.
	task rchk(input string n, input logic [3:0] a, input logic [7:0] e);
		hst.rd(a, rv);
		chk(n, rv, e);
	endtask : rchk

	// Prints the counts and the verdict, then stops.
	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// Cuts a hang short.
	initial begin
		repeat (5000) @(posedge mclk);
		n_errors++;
		complete_run();
	end

	// Main sequence of tests.
	initial begin
		{rst, ce, tsr_empty, cts_n_pin, rts_n_out} = 5'h1f;
		{enh_enable, rx_push, rx_overrun, rx_err_any, rs485_auto, bit_tick} = 6'h00;
		{auto_rts, auto_cts, xoff_match, xon_match, special_match} = 5'h00;
		{modem_delta, gpio_pin, rx_head_err, rx_count, tx_count} = 25'h0;
		n_errors = 0;
		comparisons = 0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rchk("source", SQ, 8'h01);
		rchk("enable", EN, 8'h00);
		chk("fifo_en", {7'h0, fifo_en}, 8'h00);
		$display("test reset done");
		hst.wr(SQ, 8'hc0);
		@(posedge mclk);
		chk("fifo_en", {7'h0, fifo_en}, 8'h00);
		chk("rx_trig", {1'b0, rx_trig}, 8'h08);
		hst.wr(SQ, 8'hf1);
		@(posedge mclk);
		chk("fifo_en", {7'h0, fifo_en}, 8'h01);
		chk("rx_trig", {1'b0, rx_trig}, 8'h3c);
		chk("tx_trig", {1'b0, tx_trig}, 8'h08);
		rchk("source", SQ, 8'hc1);
		$display("test queue control done");
		hst.wr(EN, 8'hf0);
		rchk("enable", EN, 8'h00);
		enh_enable <= 1'b1;
		hst.wr(EN, 8'h10);
		rchk("enable", EN, 8'h10);
		chk("sleep_en", {7'h0, sleep_en}, 8'h01);
		hst.wr(SQ, 8'hf1);
		@(posedge mclk);
		chk("tx_trig", {1'b0, tx_trig}, 8'h38);
		$display("test enable guard done");
		hst.wr(EN, 8'h02);
		repeat (2) @(posedge mclk);
		chk("irq_n", {7'h0, irq_n}, 8'h00);
		rchk("source", SQ, 8'hc2);
		rchk("source", SQ, 8'hc1);
		repeat (2) @(posedge mclk);
		chk("irq_n", {7'h0, irq_n}, 8'h01);
		tx_count <= 7'h3f;
		@(posedge mclk);
		tx_count <= 7'h00;
		repeat (2) @(posedge mclk);
		rchk("source", SQ, 8'hc2);
		hst.wr(irq_pkg::OFS_HOLDING, 8'h55);
		rchk("source", SQ, 8'hc1);
		$display("test transmit ready done");
		rx_err_any <= 1'b1;
		rx_count <= 7'h3c;
		hst.wr(EN, 8'h07);
		repeat (2) @(posedge mclk);
		rchk("source", SQ, 8'hc6);
		rx_err_any <= 1'b0;
		repeat (3) @(posedge mclk);
		rchk("source", SQ, 8'hc4);
		rx_overrun <= 1'b1;
		@(posedge mclk);
		rx_overrun <= 1'b0;
		repeat (2) @(posedge mclk);
		rchk("source", SQ, 8'hc6);
		rchk("line", irq_pkg::OFS_LINE_STATUS, 8'h63);
		rx_count <= 7'h3b;
		repeat (3) @(posedge mclk);
		rchk("source", SQ, 8'hc1);
		$display("test priority done");
		hst.wr(EN, 8'h08);
		modem_delta <= 4'h1;
		repeat (2) @(posedge mclk);
		modem_delta <= 4'h0;
		rchk("source", SQ, 8'hc0);
		hst.rd(irq_pkg::OFS_MODEM_STATE, rv);
		repeat (2) @(posedge mclk);
		rchk("source", SQ, 8'hc1);
		$display("test modem done");
		rx_count <= 7'h01;
		hst.wr(EN, 8'h01);
		bit_tick <= 1'b1;
		repeat (IDLE_TICKS - 1) @(posedge mclk);
		rchk("source", SQ, 8'hc1);
		bit_tick <= 1'b0;
		rchk("source", SQ, 8'hcc);
		hst.rd(irq_pkg::OFS_HOLDING, rv);
		rchk("source", SQ, 8'hc1);
		$display("test timeout done");
		gpio_pin <= 4'h1;
		repeat (4) @(posedge mclk);
		rchk("source", SQ, 8'hf0);
		rchk("inputs", irq_pkg::OFS_INPUT_STATE, 8'h01);
		rchk("source", SQ, 8'hc1);
		$display("test inputs done");
		hst.wr(EN, 8'h20);
		xoff_match <= 1'b1;
		@(posedge mclk);
		xoff_match <= 1'b0;
		rchk("source", SQ, 8'hd0);
		rchk("source", SQ, 8'hd0);
		xon_match <= 1'b1;
		@(posedge mclk);
		xon_match <= 1'b0;
		rchk("source", SQ, 8'hc1);
		special_match <= 1'b1;
		@(posedge mclk);
		special_match <= 1'b0;
		rchk("source", SQ, 8'hd0);
		rchk("source", SQ, 8'hc1);
		$display("test character match done");
		auto_cts <= 1'b1;
		auto_rts <= 1'b1;
		hst.wr(EN, 8'hc0);
		cts_n_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		cts_n_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		rchk("source", SQ, 8'he0);
		hst.rd(irq_pkg::OFS_MODEM_STATE, rv);
		rchk("source", SQ, 8'hc1);
		rts_n_out <= 1'b0;
		@(posedge mclk);
		rts_n_out <= 1'b1;
		repeat (2) @(posedge mclk);
		rchk("source", SQ, 8'he0);
		hst.rd(irq_pkg::OFS_MODEM_STATE, rv);
		rchk("source", SQ, 8'hc1);
		$display("test handshake done");
		complete_run();
	end
endmodule : test_uart_irq_status
